// >>> dv/stx_remote_model.sv
`timescale 1ns/1ps
module stx_remote_model
(
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // link from and to the device
    input  wire logic [stx_pkg::QUAD-1:0] txSerial,
    input  wire logic [stx_pkg::QUAD-1:0] oobSend,
    output logic      [stx_pkg::QUAD-1:0] rxSerial
);
    import stx_pkg::*;
    logic [7:0] halfCnt;
    logic       oobLevel;
    // slow square wave, sent in place of the echo on every lane whose oobSend is set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halfCnt  <= 8'h00;
            oobLevel <= 1'b0;
        end else if (halfCnt == OOB_HALF - 8'h01) begin
            halfCnt  <= 8'h00;
            oobLevel <= ~oobLevel;
        end else begin
            halfCnt <= halfCnt + 8'h01;
        end
    end
    // nrz echo with no clock line, so same width and code come back
    assign rxSerial = (oobSend & {QUAD{oobLevel}}) | (~oobSend & txSerial);
endmodule : stx_remote_model

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import stx_pkg::*;
    // design and model hookup
    logic                      clk, rst, refTick, refRun, cfgLoad, cfgBufEn, cfgErr, pllLocked;
    logic                      txClk, txWordTake, rxClk, lvl;
    logic [2:0]                cfgWidthSel;
    logic [4:0]                cfgMult, refPer, refCnt;
    stx_enc_t                  cfgEnc;
    logic [QUAD-1:0][MAXW-1:0] txWord, rxWord;
    logic [QUAD-1:0]           oobTxEn, oobSend, txSerial, rxSerial;
    logic [QUAD-1:0]           rxValid, rxCodeErr, rxAligned, oobDetected;
    int                        errors, checksDone, n;

    stx_quad_datapath #(.WIDE(1'b1), .LOCK_TICKS(4'h2)) stx_quad_datapath_inst (
        .clk(clk), .rst(rst), .refTick(refTick), .cfgLoad(cfgLoad),
        .cfgWidthSel(cfgWidthSel), .cfgEnc(cfgEnc), .cfgBufEn(cfgBufEn), .cfgMult(cfgMult),
        .cfgErr(cfgErr), .pllLocked(pllLocked), .txWord(txWord), .oobTxEn(oobTxEn),
        .txDividedWordClock(txClk), .txWordTake(txWordTake), .txSerial(txSerial),
        .rxSerial(rxSerial), .rxUserWordClock(rxClk), .rxWord(rxWord), .rxValid(rxValid),
        .rxCodeErr(rxCodeErr), .rxAligned(rxAligned), .oobDetected(oobDetected));
    stx_remote_model stx_remote_model_inst (
        .clk(clk), .rst(rst), .txSerial(txSerial), .oobSend(oobSend), .rxSerial(rxSerial));

    always #5 clk = ~clk;
    // reference pulse every refPer bit times; a wrong period must cost the lock
    always @(posedge clk) begin
        if (!refRun || refCnt == refPer - 5'h01) begin
            refCnt  <= 5'h00;
            refTick <= refRun;
        end else begin
            refCnt  <= refCnt + 5'h01;
            refTick <= 1'b0;
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check_flag(input logic got, input logic exp);
        checksDone++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check_flag

    task automatic check_val(input logic [19:0] got, input logic [19:0] exp);
        checksDone++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check_val

    function automatic logic watched(input int which);
        case (which)
            0: return txWordTake;
            1: return pllLocked;
            2: return oobDetected[0];
            default: return ~pllLocked;
        endcase
    endfunction : watched

    // bounded wait; running out ends the run as a mismatch
    task automatic wait_high(input int which, input int limit);
        for (int k = 0; k < limit && watched(which) !== 1'b1; k++) @(negedge clk);
        if (watched(which) !== 1'b1) begin
            errors++;
            give_verdict();
        end
    endtask : wait_high

    task automatic load(input logic [2:0] w, input stx_enc_t e, input logic b, input logic [4:0] m);
        @(posedge clk);
        cfgWidthSel <= w;
        cfgEnc      <= e;
        cfgBufEn    <= b;
        cfgMult     <= m;
        cfgLoad     <= 1'b1;
        @(posedge clk);
        cfgLoad <= 1'b0;
        repeat (2) @(negedge clk);
    endtask : load

    // loopback pass: lane 0 bits and word clocks, then delivery on every lane except in the 64B/67B pass
    task automatic run(input logic [2:0] w, input stx_enc_t e, input logic b, input int actW,
                       input logic [19:0] exp, input int nb);
        logic [19:0] got;
        int          hi;
        got = '0;
        hi  = 0;
        load(w, e, b, 5'h0A);
        check_flag(cfgErr, 1'b0);
        check_flag(pllLocked, 1'b0);
        wait_high(1, 200);
        wait_high(0, 400);
        for (int k = 0; k < actW; k++) begin
            @(negedge clk);
            if (k < nb) got[k] = txSerial[0];
            hi += txClk;
            check_flag(rxClk, txClk);
        end
        check_val(got, exp);
        check_val(20'(hi), 20'(actW / 2));
        repeat (3) begin
            @(negedge clk);
            wait_high(0, 400);
        end
        @(negedge clk);
        // the 3-bit 64B/67B header opens with a zero, so the echo aligns a bit late and must flag it
        if (e == ENC_64B67B) check_flag(rxCodeErr[0], 1'b1);
        for (int i = 0; i < QUAD && e != ENC_64B67B; i++) begin
            check_flag(rxAligned[i], 1'b1);
            check_flag(rxValid[i], 1'b1);
            check_flag(rxCodeErr[i], 1'b0);
            if (e == ENC_NONE) check_val(rxWord[i][19:0], txWord[i][19:0]);
        end
    endtask : run

    initial begin
        clk = 1'b0; rst = 1'b1; refRun = 1'b0; refPer = 5'h0A; refCnt = 5'h00; refTick = 1'b0;
        cfgLoad = 1'b0; cfgWidthSel = 3'h3; cfgEnc = ENC_NONE; cfgBufEn = 1'b0; cfgMult = 5'h0A;
        oobTxEn = 4'h0; oobSend = 4'h0; errors = 0; checksDone = 0; txWord = '0;
        for (int i = 0; i < QUAD; i++) txWord[i][15:0] = 16'hA5C3 ^ 16'(i << 4);
        repeat (12) @(posedge clk);
        check_flag(pllLocked, 1'b0);
        check_flag(txWordTake, 1'b0);
        rst <= 1'b0;
        @(posedge clk);
        refRun <= 1'b1;
        run(3'h0, ENC_NONE, 1'b0, 16, 20'h0A5C3, 16);
        run(3'h1, ENC_8B10B, 1'b1, 20, 20'h001C3, 10);
        run(3'h0, ENC_64B66B, 1'b0, 16, 20'h00001, 2);
        run(3'h0, ENC_64B67B, 1'b0, 16, 20'h00002, 3);
        run(3'h7, ENC_NONE, 1'b0, 160, 20'h0A5C3, 16);
        // refused loads keep the old setup and the lock
        load(3'h0, ENC_8B10B, 1'b0, 5'h0A);
        check_flag(cfgErr, 1'b1);
        load(3'h3, ENC_NONE, 1'b0, 5'h03);
        check_flag(cfgErr, 1'b1);
        load(3'h3, ENC_NONE, 1'b0, 5'h1A);
        check_flag(cfgErr, 1'b1);
        check_flag(pllLocked, 1'b1);
        load(3'h3, ENC_NONE, 1'b0, 5'h04);
        check_flag(cfgErr, 1'b0);
        load(3'h3, ENC_NONE, 1'b0, 5'h19);
        check_flag(cfgErr, 1'b0);
        @(posedge clk);
        refPer <= 5'h19;
        wait_high(1, 600);
        check_flag(pllLocked, 1'b1);
        // slow signalling both ways while data idles; lane 0 sends too so its checker fires
        @(posedge clk);
        oobTxEn <= 4'h3;
        oobSend <= 4'h1;
        wait_high(2, 400);
        check_flag(oobDetected[0], 1'b1);
        repeat (2) @(negedge clk);
        check_flag(rxAligned[0], 1'b0);
        lvl = txSerial[1];
        for (n = 0; n < 100 && txSerial[1] === lvl; n++) @(negedge clk);
        lvl = txSerial[1];
        for (n = 0; n < 100 && txSerial[1] === lvl; n++) @(negedge clk);
        check_val(20'(n), 20'(OOB_HALF));
        // a reference period one bit short must drop the lock
        @(posedge clk);
        refPer <= 5'h18;
        wait_high(3, 100);
        check_flag(pllLocked, 1'b0);
        give_verdict();
    end
endmodule : testbench

// >>> src/stx_oob_detect.sv
`timescale 1ns/1ps
module stx_oob_detect #(
    parameter logic [7:0] MIN_RUN = stx_pkg::OOB_MIN_RUN,
    parameter logic [7:0] MAX_RUN = stx_pkg::OOB_MAX_RUN,
    parameter logic [2:0] EDGES   = stx_pkg::OOB_EDGES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // serial line and result
    input  wire logic lineIn,
    output logic      detected
);
    import stx_pkg::*;

    logic       lastLevel;
    logic [7:0] runLen;
    logic [2:0] edgeCnt;
    logic [2:0] next_edgeCnt;

    // a burst is a run of slow edges; a data level held MAX_RUN bits or more clears the edge count
    wire lineEdge = lineIn != lastLevel;
    wire staleRun = runLen >= MAX_RUN;
    wire longRun  = (runLen >= MIN_RUN) && !staleRun;

    always_comb begin
        next_edgeCnt = edgeCnt;
        if (lineEdge) begin
            next_edgeCnt = longRun ? ((edgeCnt == EDGES) ? edgeCnt : edgeCnt + 3'h1) : '0;
        end else if (staleRun) begin
            next_edgeCnt = '0; // line went quiet, burst over
        end
    end

    // run length saturates so that a quiet line cannot wrap into a burst
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lastLevel <= 1'b0;
            runLen    <= '0;
            edgeCnt   <= '0;
            detected  <= 1'b0;
        end else begin
            lastLevel <= lineIn;
            runLen    <= lineEdge ? '0 : (staleRun ? runLen : runLen + 8'h01);
            edgeCnt   <= next_edgeCnt;
            detected  <= next_edgeCnt >= EDGES; // RULE11
        end
    end

endmodule : stx_oob_detect

// >>> src/stx_pkg.sv
package stx_pkg;

    // channel grouping and word sizes
    localparam int QUAD    = 4;
    localparam int MAXW    = 160;
    localparam int GROUPS  = 16;
    localparam int CODE_W  = 10;
    localparam int DATA_W  = 8;
    localparam int HDR66_W = 2;
    localparam int HDR67_W = 3;

    // sync headers of the block codes, sent least significant bit first
    localparam logic [1:0] HDR66 = 2'h1;
    localparam logic [2:0] HDR67 = 3'h2;

    // reference multiplier range and reset values
    localparam logic [4:0] MULT_MIN = 5'h04;
    localparam logic [4:0] MULT_MAX = 5'h19;
    localparam logic [4:0] MULT_RST = 5'h0A;
    localparam logic [7:0] W_RST    = 8'h28;
    localparam logic [3:0] LOCK_N   = 4'h8;

    // out-of-band signalling timing in bit times, and the edge count of a burst
    localparam logic [7:0] OOB_HALF    = 8'h20;
    localparam logic [7:0] OOB_MIN_RUN = 8'h18;
    localparam logic [7:0] OOB_MAX_RUN = 8'h40;
    localparam logic [2:0] OOB_EDGES   = 3'h4;

    typedef enum logic [1:0] {
        ENC_NONE   = 2'h0,
        ENC_8B10B  = 2'h1,
        ENC_64B66B = 2'h2,
        ENC_64B67B = 2'h3
    } stx_enc_t;

    // serial word length for a width code; zero marks an illegal code
    function automatic logic [7:0] stx_width_of(input logic [2:0] sel, input logic wide);
        logic [7:0] w;
        unique case (sel)
            3'h0: w = 8'h10;
            3'h1: w = 8'h14;
            3'h2: w = 8'h20;
            3'h3: w = 8'h28;
            3'h4: w = 8'h40;
            3'h5: w = 8'h50;
            3'h6: w = wide ? 8'h80 : 8'h00;
            3'h7: w = wide ? 8'hA0 : 8'h00;
        endcase
        return w;
    endfunction : stx_width_of

endpackage : stx_pkg

// >>> src/stx_quad_datapath.sv
`timescale 1ns/1ps
// Behaviour
// RULE1 - channels come in quads of four, each with transmit and receive
// RULE2 - bit clock is reference times an integer factor from 4 to 25
// RULE3 - transmit serialises words of 16 to 80 bits, wide variant up to 160
// RULE4 - a divided word clock marks when outgoing words are registered
// RULE5 - transmit words pass a buffer stage that configuration enables or bypasses
// RULE6 - transmit offers 8B/10B, 64B/66B, 64B/67B or no line encoding
// RULE7 - receive deserialises into words of the same selectable widths
// RULE8 - receiver recovers timing from the data, no separate clock line
// RULE9 - serial line is NRZ; both ends must use the same encoding
// RULE10 - received words reach the user on the receive user clock
// RULE11 - low-speed out-of-band bursts are sent and detected while data idles
// RULE12 - configuration loads at start and can change during operation
// RULE13 - one word per user clock each way, same width and encoding both ends
module stx_quad_datapath #(
    parameter bit         WIDE       = 1'b1,
    parameter logic [3:0] LOCK_TICKS = stx_pkg::LOCK_N
) (
    // clock and reset
    input  wire logic                                            clk,
    input  wire logic                                            rst,
    // reference clock edge, one pulse per reference period
    input  wire logic                                            refTick,
    // configuration
    input  wire logic                                            cfgLoad,
    input  wire logic [2:0]                                      cfgWidthSel,
    input  wire stx_pkg::stx_enc_t                               cfgEnc,
    input  wire logic                                            cfgBufEn,
    input  wire logic [4:0]                                      cfgMult,
    output logic                                                 cfgErr,
    output logic                                                 pllLocked,
    // transmit user side
    input  wire logic [stx_pkg::QUAD-1:0][stx_pkg::MAXW-1:0]     txWord,
    input  wire logic [stx_pkg::QUAD-1:0]                        oobTxEn,
    output logic                                                 txDividedWordClock,
    output logic                                                 txWordTake,
    // serial link
    output logic [stx_pkg::QUAD-1:0]                             txSerial,
    input  wire logic [stx_pkg::QUAD-1:0]                        rxSerial,
    // receive user side
    output logic                                                 rxUserWordClock,
    output logic [stx_pkg::QUAD-1:0][stx_pkg::MAXW-1:0]          rxWord,
    output logic [stx_pkg::QUAD-1:0]                             rxValid,
    output logic [stx_pkg::QUAD-1:0]                             rxCodeErr,
    output logic [stx_pkg::QUAD-1:0]                             rxAligned,
    output logic [stx_pkg::QUAD-1:0]                             oobDetected
);
    import stx_pkg::*;

    function automatic logic [MAXW-1:0] maskOf(input logic [7:0] w);
        logic [MAXW-1:0] m;
        m = '0;
        for (int b = 0; b < MAXW; b++) m[b] = b < w;
        return m;
    endfunction : maskOf

    // line encoder; the 8B/10B form keeps a forced edge between bits 8 and 9 of each symbol
    function automatic logic [MAXW-1:0] encWord(input logic [MAXW-1:0] d,
                                               input logic [7:0] w, input stx_enc_t e);
        logic [MAXW-1:0] r;
        r = d;
        unique case (e)
            ENC_NONE:   r = d;
            ENC_8B10B:  for (int g = 0; g < GROUPS; g++)
                            r[g*CODE_W +: CODE_W] = {~d[g*DATA_W+DATA_W-1],
                                                     d[g*DATA_W+DATA_W-1], d[g*DATA_W +: DATA_W]};
            ENC_64B66B: r = {d[MAXW-HDR66_W-1:0], HDR66};
            ENC_64B67B: r = {d[MAXW-HDR67_W-1:0], HDR67};
        endcase
        return r & maskOf(w);
    endfunction : encWord

    function automatic logic [MAXW-1:0] decWord(input logic [MAXW-1:0] r, input stx_enc_t e);
        logic [MAXW-1:0] d;
        d = r;
        unique case (e)
            ENC_NONE:   d = r;
            ENC_8B10B:  begin
                d = '0;
                for (int g = 0; g < GROUPS; g++) d[g*DATA_W +: DATA_W] = r[g*CODE_W +: DATA_W];
            end
            ENC_64B66B: d = r >> HDR66_W;
            ENC_64B67B: d = r >> HDR67_W;
        endcase
        return d;
    endfunction : decWord

    function automatic logic codeOk(input logic [MAXW-1:0] r, input logic [7:0] w,
                                    input stx_enc_t e);
        logic ok;
        ok = 1'b1;
        unique case (e)
            ENC_NONE:   ok = 1'b1;
            ENC_8B10B:  for (int g = 0; g < GROUPS; g++)
                            if ((g + 1) * CODE_W <= w && r[g*CODE_W+DATA_W] == r[g*CODE_W+DATA_W+1])
                                ok = 1'b0;
            ENC_64B66B: ok = r[HDR66_W-1:0] == HDR66;
            ENC_64B67B: ok = r[HDR67_W-1:0] == HDR67;
        endcase
        return ok;
    endfunction : codeOk

    logic [7:0] actW;
    stx_enc_t   actEnc;
    logic       actBuf;
    logic [4:0] actMult;
    logic [4:0] refBits;
    logic [3:0] lockCnt;
    logic [3:0] next_lockCnt;
    logic [7:0] bitCnt;
    logic [7:0] next_bitCnt;
    logic [7:0] oobCnt;
    logic       oobPhase;

    // configuration checks; 8B/10B needs a whole number of symbols per word
    wire [7:0] reqW      = stx_width_of(cfgWidthSel, WIDE);
    wire       multOk    = cfgMult >= MULT_MIN && cfgMult <= MULT_MAX;
    wire       encFits   = cfgEnc != ENC_8B10B || (reqW % CODE_W) == 0;
    wire       legalCfg  = reqW != 8'h00 && multOk && encFits;
    wire       cfgApply  = cfgLoad && legalCfg;
    wire       refMatch  = refBits == actMult - 5'h01;
    wire       bitLast   = bitCnt == actW - 8'h01;
    wire       oobWrap   = oobCnt == OOB_HALF - 8'h01;

    // a rejected load keeps the running setup, so a typo never drops the link
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            actW    <= W_RST;
            actEnc  <= ENC_NONE;
            actBuf  <= 1'b0;
            actMult <= MULT_RST;
            cfgErr  <= 1'b0;
        end else if (cfgLoad) begin
            cfgErr <= !legalCfg; // RULE12
            if (legalCfg) begin
                actW    <= reqW;
                actEnc  <= cfgEnc;
                actBuf  <= cfgBufEn;
                actMult <= cfgMult;
            end
        end
    end

    // lock needs LOCK_TICKS reference periods of exactly actMult bit times
    assign next_lockCnt = cfgApply ? '0 :
                          !refTick ? lockCnt :
                          !refMatch ? '0 :
                          (lockCnt == LOCK_TICKS) ? lockCnt : lockCnt + 4'h1; // RULE2

    // shared word counter; restarts on every applied configuration
    assign next_bitCnt = (cfgApply || !pllLocked || bitLast) ? '0 : bitCnt + 8'h01; // RULE3

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refBits            <= '0;
            lockCnt            <= '0;
            pllLocked          <= 1'b0;
            bitCnt             <= '0;
            txWordTake         <= 1'b0;
            txDividedWordClock <= 1'b0;
            rxUserWordClock    <= 1'b0;
            oobCnt             <= '0;
            oobPhase           <= 1'b0;
        end else begin
            refBits            <= refTick ? '0 : ((refBits == '1) ? refBits : refBits + 5'h01);
            lockCnt            <= next_lockCnt;
            pllLocked          <= next_lockCnt == LOCK_TICKS;
            bitCnt             <= next_bitCnt;
            txWordTake         <= pllLocked && bitLast && !cfgApply; // RULE13
            txDividedWordClock <= pllLocked && next_bitCnt < (actW >> 1); // RULE4
            rxUserWordClock    <= pllLocked && next_bitCnt < (actW >> 1); // RULE10
            oobCnt             <= oobWrap ? '0 : oobCnt + 8'h01;
            oobPhase           <= oobWrap ? !oobPhase : oobPhase; // RULE11
        end
    end

    for (genvar i = 0; i < QUAD; i++) begin : g_lane // RULE1
        logic [MAXW-1:0] bufWord;
        logic [MAXW-1:0] shiftReg;
        logic            txBit;
        logic            rxPrev;
        logic            aligned;
        logic [7:0]      rxCnt;
        logic [MAXW-1:0] rxShift;
        logic [MAXW-1:0] rxHold;
        logic            holdNew;
        logic            holdErr;
        logic [MAXW-1:0] wordOut;
        logic            validOut;
        logic            errOut;
        logic            oobSeen;

        // buffered mode costs one word of latency but lets the user run ahead a word
        wire [MAXW-1:0] srcWord = actBuf ? bufWord : txWord[i]; // RULE5
        wire [MAXW-1:0] encW    = encWord(srcWord, actW, actEnc); // RULE6
        wire            lineEdge = rxSerial[i] != rxPrev;
        wire            rxLast  = rxCnt == actW - 8'h01;
        wire [MAXW-1:0] rawNow  = rxShift | ({{(MAXW-1){1'b0}}, rxSerial[i]} << rxCnt);
        wire            rxStop  = !pllLocked || cfgApply || oobSeen;

        // transmit: load at the word boundary, then shift out least significant bit first
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                bufWord  <= '0;
                shiftReg <= '0;
                txBit    <= 1'b0;
            end else if (txWordTake) begin
                bufWord  <= txWord[i]; // RULE5
                shiftReg <= encW >> 1;
                txBit    <= oobTxEn[i] ? oobPhase : encW[0]; // RULE9
            end else if (!pllLocked || cfgApply) begin
                shiftReg <= '0; // idle low, or the far end aligns on a stale bit
                txBit    <= oobTxEn[i] ? oobPhase : 1'b0; // RULE8
            end else begin
                shiftReg <= shiftReg >> 1; // RULE3
                txBit    <= oobTxEn[i] ? oobPhase : shiftReg[0]; // RULE11
            end
        end

        // receive: the first edge after lock marks bit 0 of a word, no clock line is used
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                rxPrev  <= 1'b0;
                aligned <= 1'b0;
                rxCnt   <= '0;
                rxShift <= '0;
                rxHold  <= '0;
                holdNew <= 1'b0;
                holdErr <= 1'b0;
            end else begin
                rxPrev <= rxSerial[i];
                if (txWordTake) holdNew <= 1'b0;
                if (rxStop) begin
                    aligned <= 1'b0;
                    rxCnt   <= '0;
                    rxShift <= '0;
                end else if (!aligned) begin
                    if (lineEdge) begin
                        aligned <= 1'b1; // RULE8
                        rxCnt   <= 8'h01;
                        rxShift <= {{(MAXW-1){1'b0}}, rxSerial[i]};
                    end
                end else if (rxLast) begin
                    rxHold  <= decWord(rawNow, actEnc); // RULE7
                    holdErr <= !codeOk(rawNow, actW, actEnc); // RULE9
                    holdNew <= 1'b1; // a finished word wins over the hand-off clear
                    rxCnt   <= '0;
                    rxShift <= '0;
                end else begin
                    rxCnt   <= rxCnt + 8'h01;
                    rxShift <= rawNow;
                end
            end
        end

        // hand-off on the user word boundary, never on the recovered bit timing
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                wordOut  <= '0;
                validOut <= 1'b0;
                errOut   <= 1'b0;
            end else if (txWordTake) begin
                wordOut  <= rxHold; // RULE10
                validOut <= holdNew; // RULE13
                errOut   <= holdNew && holdErr;
            end
        end

        stx_oob_detect u_oob (
            .clk      (clk),
            .rst      (rst),
            .lineIn   (rxSerial[i]),
            .detected (oobSeen)
        );

        assign txSerial[i]    = txBit;
        assign rxWord[i]      = wordOut;
        assign rxValid[i]     = validOut;
        assign rxCodeErr[i]   = errOut;
        assign rxAligned[i]   = aligned;
        assign oobDetected[i] = oobSeen;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wire [MAXW-1:0] chkEnc0 = encWord(txWord[0], actW, actEnc);

    property p_ref_mismatch;
        refTick && !refMatch |=> !pllLocked;
    endproperty
    a_ref_mismatch: assert property (p_ref_mismatch) else $error("lock kept on bad ratio"); // RULE2
    property p_word_len;
        pllLocked && bitLast && !cfgApply |=> txWordTake ##1 !txWordTake;
    endproperty
    a_word_len: assert property (p_word_len) else $error("word take not at word end"); // RULE3
    property p_take_clock;
        txWordTake |-> bitCnt == 8'h00 && txDividedWordClock && rxUserWordClock;
    endproperty
    a_take_clock: assert property (p_take_clock) else $error("word clock not high at take"); // RULE4
    property p_bypass;
        txWordTake && !actBuf && !oobTxEn[0] |=> txSerial[0] == $past(chkEnc0[0]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass bit 0 wrong"); // RULE5
    property p_buffered;
        txWordTake && actBuf |=> g_lane[0].bufWord == $past(txWord[0]);
    endproperty
    a_buffered: assert property (p_buffered) else $error("buffer did not catch word"); // RULE5
    property p_hdr66;
        txWordTake && actEnc == ENC_64B66B && !oobTxEn[0] ##1 !oobTxEn[0]
            |-> txSerial[0] == HDR66[0] ##1 txSerial[0] == HDR66[1];
    endproperty
    a_hdr66: assert property (p_hdr66) else $error("sync header not sent first"); // RULE6
    property p_rx_word;
        g_lane[0].aligned && g_lane[0].rxLast && !g_lane[0].rxStop
            |=> g_lane[0].holdNew && g_lane[0].rxCnt == 8'h00;
    endproperty
    a_rx_word: assert property (p_rx_word) else $error("receive word length wrong"); // RULE7
    property p_align;
        !g_lane[0].aligned && !g_lane[0].rxStop && g_lane[0].lineEdge |=> rxAligned[0];
    endproperty
    a_align: assert property (p_align) else $error("no alignment on first edge"); // RULE8
    property p_code_err;
        txWordTake && g_lane[0].holdNew |=> rxCodeErr[0] == $past(g_lane[0].holdErr);
    endproperty
    a_code_err: assert property (p_code_err) else $error("code error not reported"); // RULE9
    property p_rx_user;
        !$stable(rxWord[0]) || $rose(rxValid[0]) |-> $past(txWordTake);
    endproperty
    a_rx_user: assert property (p_rx_user) else $error("rx word moved off boundary"); // RULE10
    property p_oob_tx;
        oobTxEn[0] |=> txSerial[0] == $past(oobPhase);
    endproperty
    a_oob_tx: assert property (p_oob_tx) else $error("oob level wrong"); // RULE11
    property p_cfg_apply;
        cfgApply |=> actW == $past(reqW) && bitCnt == 8'h00 && !cfgErr && !pllLocked;
    endproperty
    a_cfg_apply: assert property (p_cfg_apply) else $error("config not applied"); // RULE12
    property p_cfg_reject;
        cfgLoad && !legalCfg |=> cfgErr && $stable(actW) && $stable(actMult);
    endproperty
    a_cfg_reject: assert property (p_cfg_reject) else $error("bad config accepted"); // RULE12

    c_lock:   cover property ($rose(pllLocked));
    c_rx:     cover property (rxValid[0] && !rxCodeErr[0]);
    c_oob:    cover property ($rose(oobDetected[0]));
    c_reject: cover property (cfgLoad && !legalCfg);

endmodule : stx_quad_datapath
